// ==== common/dio_cond_params.svh ====
// constants for the digital i/o channel conditioner
`ifndef DIO_COND_PARAMS_SVH
`define DIO_COND_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define A_CTRL      8'h00
`define A_FAULT     8'h04
`define A_IDLE      8'h08
`define A_THRESH    8'h0c
`define A_STATUS    8'h10
`define A_MASK      8'h14
`define A_LIVE      8'h18
`define A_COUNT     8'h20
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define B_SUP_EN    0
`define B_INRUSH_EN 1
`define B_OSC_EN    2
`define B_RST_MODE  3
`define B_OPEN_EN   4
`define B_CNT_EN    5
`define B_HANDHELD  6
`define F_FILT_LO   8
`define F_STR_LO    10
// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define S_SUP       0
`define S_OSC       1
`define S_OPEN_LO   8
`define S_CNT_LO    16
// ----------------------------------------------------------------
// reset values and the threshold ceiling
// ----------------------------------------------------------------
`define CTRL_RST    32'h0000_0505
`define ACT_RST     32'h0000_0000
`define THRESH_RST  16'h0001
`define THR_MAX     16'hfde8
// ----------------------------------------------------------------
// timing, in the unit named by each suffix, and the threshold count scale
// ----------------------------------------------------------------
`define CLK_MHZ     200
`define FILT_T0_US  100
`define FILT_T1_US  1000
`define FILT_T2_US  10000
`define FILT_T3_US  20000
`define STR_T0_US   1000
`define STR_T1_US   15000
`define STR_T2_US   100000
`define STR_T3_US   200000
`define INRUSH_US   100000
`define SAVE_S      3600
`define CNT_SCALE   1000
`endif

// ==== common/dio_cond_pkg.sv ====
// types shared by the digital i/o channel conditioner
package dio_cond_pkg;
   typedef enum logic [1:0] {
      ACT_CLEAR         = 2'h0,
      ACT_HOLD          = 2'h1,
      DRIVE_HIGH_FORCED = 2'h2
   } out_action_t;
   typedef enum logic [2:0] {
      SEQ_RESTORE = 3'h1,
      SEQ_RUN     = 3'h2,
      SEQ_SAVE    = 3'h4
   } seq_state_t;
endpackage

// ==== verilog/on_count_store.sv ====
// retained store for the per-channel on counts
`timescale 1ns/1ps
module on_count_store #(
   parameter int DW    = 32,
   parameter int DEPTH = 4,
   parameter int AW    = 2
)(
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [DEPTH];
   // contents start at zero once; rst_i never touches them
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = '0;
      end
   end
   // write port
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end
   // registered read
   always_ff @(posedge clk_i) begin
      rdata_o <= mem[raddr_i];
   end
endmodule

// ==== verilog/dio_channel_conditioner.sv ====
// digital i/o channel conditioner: filter, stretch, faults, safe outputs, on counters
`timescale 1ns/1ps
`include "dio_cond_params.svh"
module dio_channel_conditioner #(
   parameter int          CH         = 4,
   parameter int          TW         = 26,
   parameter int unsigned FILT0_CYC  = `FILT_T0_US * `CLK_MHZ,
   parameter int unsigned FILT1_CYC  = `FILT_T1_US * `CLK_MHZ,
   parameter int unsigned FILT2_CYC  = `FILT_T2_US * `CLK_MHZ,
   parameter int unsigned FILT3_CYC  = `FILT_T3_US * `CLK_MHZ,
   parameter int unsigned STR0_CYC   = `STR_T0_US * `CLK_MHZ,
   parameter int unsigned STR1_CYC   = `STR_T1_US * `CLK_MHZ,
   parameter int unsigned STR2_CYC   = `STR_T2_US * `CLK_MHZ,
   parameter int unsigned STR3_CYC   = `STR_T3_US * `CLK_MHZ,
   parameter int unsigned INRUSH_CYC = `INRUSH_US * `CLK_MHZ,
   parameter logic [39:0] SAVE_CYC   = 40'(64'(`SAVE_S) * 64'd1000000 * 64'(`CLK_MHZ))
)(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [CH-1:0] in_pin_i,
   input  wire logic [CH-1:0] out_cmd_i,
   input  wire logic          comm_fault_i,
   input  wire logic          comm_idle_i,
   input  wire logic          out_short_pin_i,
   input  wire logic          supply_short_pin_i,
   input  wire logic [CH-1:0] out_open_pin_i,
   output logic      [CH-1:0] in_val_o,
   output logic      [CH-1:0] out_drv_o,
   output logic               irq_o
);
   import dio_cond_pkg::*;
   localparam int AW = (CH > 1) ? $clog2(CH) : 1;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [CH-1:0] in_s1, in_s2, open_s1, open_s2;
   logic [1:0]    sh_s1, sh_s2;
   // first stage is read only by the second
   always_ff @(posedge clk_i) begin
      in_s1   <= in_pin_i;
      in_s2   <= in_s1;
      open_s1 <= out_open_pin_i;
      open_s2 <= open_s1;
      sh_s1   <= {supply_short_pin_i, out_short_pin_i};
      sh_s2   <= sh_s1;
   end

   // ---------------------------------------------------------------
   // registers and bus slave
   // ---------------------------------------------------------------
   logic [31:0] ctrl_reg, fault_act_reg, idle_act_reg, status_reg, mask_reg, status_set;
   logic [15:0] thresh_reg;
   logic [31:0] rdata, bmask, wval;
   logic        ack_reg, wr_stb, irq_reg;
   logic [31:0] cnt_reg [CH];
   assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
   assign wval   = wb_dat_i & bmask;
   // one wait state, ack dropped the cycle after it is given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_reg  <= wb_cyc_i && wb_stb_i && !ack_reg;
         wb_dat_o <= rdata;
      end
   end
   assign wb_ack_o = ack_reg;
   // software written settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg      <= `CTRL_RST;
         fault_act_reg <= `ACT_RST;
         idle_act_reg  <= `ACT_RST;
         mask_reg      <= 32'h0;
      end else if (wr_stb) begin
         case (wb_adr_i)
            `A_CTRL:  ctrl_reg      <= (ctrl_reg & ~bmask) | wval;
            `A_FAULT: fault_act_reg <= (fault_act_reg & ~bmask) | wval;
            `A_IDLE:  idle_act_reg  <= (idle_act_reg & ~bmask) | wval;
            `A_MASK:  mask_reg      <= (mask_reg & ~bmask) | wval;
            default:  ;
         endcase
      end
   end
   // set value is kept inside its legal span of 1 to 65000
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thresh_reg <= `THRESH_RST;
      end else if (wr_stb && wb_adr_i == `A_THRESH && wb_sel_i[1:0] == 2'h3) begin
         if (wb_dat_i[15:0] == 16'h0) thresh_reg <= `THRESH_RST;
         else if (wb_dat_i[15:0] > `THR_MAX) thresh_reg <= `THR_MAX;
         else thresh_reg <= wb_dat_i[15:0];
      end
   end
   // sticky events, write one to clear, a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= 32'h0;
      end else if (wr_stb && wb_adr_i == `A_STATUS) begin
         status_reg <= (status_reg & ~wval) | status_set;
      end else begin
         status_reg <= status_reg | status_set;
      end
   end
   // level interrupt, one cycle behind the status
   always_ff @(posedge clk_i) begin
      if (rst_i) irq_reg <= 1'b0;
      else irq_reg <= |(status_reg & mask_reg);
   end
   assign irq_o = irq_reg;

   // ---------------------------------------------------------------
   // unit-level settings decode
   // ---------------------------------------------------------------
   logic [TW-1:0] filt_lim, str_lim;
   logic [31:0]   cnt_lim;
   always_comb begin
      unique case (ctrl_reg[`F_FILT_LO +: 2])
         2'h0: filt_lim = TW'(FILT0_CYC);
         2'h1: filt_lim = TW'(FILT1_CYC);
         2'h2: filt_lim = TW'(FILT2_CYC);
         2'h3: filt_lim = TW'(FILT3_CYC);
      endcase
      unique case (ctrl_reg[`F_STR_LO +: 2])
         2'h0: str_lim = TW'(STR0_CYC);
         2'h1: str_lim = TW'(STR1_CYC);
         2'h2: str_lim = TW'(STR2_CYC);
         2'h3: str_lim = TW'(STR3_CYC);
      endcase
   end
   assign cnt_lim = 32'(thresh_reg) * 32'(`CNT_SCALE);

   // ---------------------------------------------------------------
   // unit short errors
   // ---------------------------------------------------------------
   logic [TW-1:0] inrush_cnt;
   logic          osc_err_reg, sup_err_reg, osc_hit;
   logic [CH-1:0] in_val_reg, in_prev_reg, out_drv_reg, out_prev_reg, filt_reg;
   // any output turning on opens a masking window
   always_ff @(posedge clk_i) begin
      if (rst_i) inrush_cnt <= '0;
      else if (|(out_drv_reg & ~out_prev_reg)) inrush_cnt <= TW'(INRUSH_CYC);
      else if (inrush_cnt != '0) inrush_cnt <= inrush_cnt - 1'b1;
   end
   // inrush filter is off after reset, so excess current counts at once
   assign osc_hit = ctrl_reg[`B_OSC_EN] && sh_s2[0]
                    && !(ctrl_reg[`B_INRUSH_EN] && inrush_cnt != '0);
   // auto restart clears with the short, manual waits for power-up
   always_ff @(posedge clk_i) begin
      if (rst_i) osc_err_reg <= 1'b0;
      else if (osc_hit) osc_err_reg <= 1'b1;
      else if (!ctrl_reg[`B_RST_MODE] && !sh_s2[0]) osc_err_reg <= 1'b0;
   end
   // supply short follows the pin while detection is on
   always_ff @(posedge clk_i) begin
      if (rst_i) sup_err_reg <= 1'b0;
      else sup_err_reg <= ctrl_reg[`B_SUP_EN] && sh_s2[1];
   end

   // ---------------------------------------------------------------
   // counter save and restore sequencer
   // ---------------------------------------------------------------
   seq_state_t    seq_reg;
   logic [AW-1:0] idx_reg, rd_idx_reg;
   logic          rd_pend_reg;
   logic [39:0]   hour_reg;
   logic [31:0]   nv_rdata;
   // restore every channel after reset, then save them hourly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_reg     <= SEQ_RESTORE;
         idx_reg     <= '0;
         rd_pend_reg <= 1'b0;
         rd_idx_reg  <= '0;
         hour_reg    <= 40'h0;
      end else begin
         rd_pend_reg <= seq_reg == SEQ_RESTORE;
         rd_idx_reg  <= idx_reg;
         unique case (seq_reg)
            SEQ_RESTORE, SEQ_SAVE: begin
               idx_reg <= (idx_reg == AW'(CH - 1)) ? '0 : idx_reg + 1'b1;
               if (idx_reg == AW'(CH - 1)) seq_reg <= SEQ_RUN;
            end
            SEQ_RUN: begin
               hour_reg <= (hour_reg == SAVE_CYC - 40'h1) ? 40'h0 : hour_reg + 40'h1;
               if (hour_reg == SAVE_CYC - 40'h1) seq_reg <= SEQ_SAVE;
            end
         endcase
      end
   end
   on_count_store #(.DW(32), .DEPTH(CH), .AW(AW)) u_store (
      .clk_i   (clk_i),
      .we_i    (seq_reg == SEQ_SAVE),
      .waddr_i (idx_reg),
      .wdata_i (cnt_reg[idx_reg]),
      .raddr_i (idx_reg),
      .rdata_o (nv_rdata)
   );

   // ---------------------------------------------------------------
   // per-channel logic
   // ---------------------------------------------------------------
   logic [TW-1:0] fcnt_reg [CH];
   logic [TW-1:0] scnt_reg [CH];
   logic [CH-1:0] open_set, cnt_set;
   logic          handheld;
   assign handheld = ctrl_reg[`B_HANDHELD];
   for (genvar c = 0; c < CH; c++) begin : g_ch
      out_action_t act;
      // a change must stand for the whole filter time
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            filt_reg[c] <= 1'b0;
            fcnt_reg[c] <= '0;
         end else if (in_s2[c] != filt_reg[c]) begin
            if (fcnt_reg[c] >= filt_lim - 1'b1) begin
               filt_reg[c] <= in_s2[c];
               fcnt_reg[c] <= '0;
            end else begin
               fcnt_reg[c] <= fcnt_reg[c] + 1'b1;
            end
         end else begin
            fcnt_reg[c] <= '0;
         end
      end
      // accepted state is held for the stretch time
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            in_val_reg[c] <= 1'b0;
            scnt_reg[c]   <= '0;
         end else if (scnt_reg[c] != '0) begin
            scnt_reg[c] <= scnt_reg[c] - 1'b1;
         end else if (filt_reg[c] != in_val_reg[c]) begin
            in_val_reg[c] <= filt_reg[c];
            scnt_reg[c]   <= str_lim - 1'b1;
         end
      end
      // actions only count when the handheld owns hold/clear priority
      always_comb begin
         if (handheld && comm_fault_i) act = out_action_t'(fault_act_reg[2*c +: 2]);
         else if (handheld && comm_idle_i) act = out_action_t'(idle_act_reg[2*c +: 2]);
         else act = ACT_HOLD;
      end
      // without handheld priority a bad link still drives the safe state
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            out_drv_reg[c] <= 1'b0;
         end else if (!comm_fault_i && !comm_idle_i) begin
            out_drv_reg[c] <= out_cmd_i[c];
         end else if (!handheld) begin
            out_drv_reg[c] <= 1'b0;
         end else begin
            case (act)
               ACT_CLEAR:         out_drv_reg[c] <= 1'b0;
               ACT_HOLD:          out_drv_reg[c] <= out_drv_reg[c];
               DRIVE_HIGH_FORCED: out_drv_reg[c] <= 1'b1;
               default:           out_drv_reg[c] <= 1'b0;
            endcase
         end
      end
      // restored value wins over a coincident edge
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cnt_reg[c] <= 32'h0;
         end else if (rd_pend_reg && rd_idx_reg == AW'(c)) begin
            cnt_reg[c] <= nv_rdata;
         end else if ((in_val_reg[c] && !in_prev_reg[c])
                      || (out_drv_reg[c] && !out_prev_reg[c])) begin
            cnt_reg[c] <= cnt_reg[c] + 32'h1;
         end
      end
      assign open_set[c] = ctrl_reg[`B_OPEN_EN] && open_s2[c];
      assign cnt_set[c]  = ctrl_reg[`B_CNT_EN] && (cnt_reg[c] > cnt_lim);
   end
   // previous values for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_prev_reg  <= '0;
         out_prev_reg <= '0;
      end else begin
         in_prev_reg  <= in_val_reg;
         out_prev_reg <= out_drv_reg;
      end
   end
   assign in_val_o  = in_val_reg;
   assign out_drv_o = out_drv_reg;

   // event collection and read mux
   always_comb begin
      status_set = 32'h0;
      status_set[`S_SUP] = sup_err_reg;
      status_set[`S_OSC] = osc_err_reg;
      status_set[`S_OPEN_LO +: CH] = open_set;
      status_set[`S_CNT_LO +: CH]  = cnt_set;
      rdata = 32'h0;
      case (wb_adr_i)
         `A_CTRL:   rdata = ctrl_reg;
         `A_FAULT:  rdata = fault_act_reg;
         `A_IDLE:   rdata = idle_act_reg;
         `A_THRESH: rdata = {16'h0, thresh_reg};
         `A_STATUS: rdata = status_reg;
         `A_MASK:   rdata = mask_reg;
         `A_LIVE:   rdata = {8'h0, 8'(out_drv_reg), 8'(in_val_reg), 6'h0, sup_err_reg, osc_err_reg};
         default: begin
            for (int i = 0; i < CH; i++) begin
               if (wb_adr_i == `A_COUNT + 8'(4 * i)) rdata = cnt_reg[i];
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_FILT_TIME: assert property ($changed(filt_reg[0]) |-> $past(fcnt_reg[0]) == filt_lim - 1'b1)
      else $error("filter accepted early");
   AST_STRETCH: assert property ($changed(in_val_reg[0]) |-> $past(scnt_reg[0]) == '0)
      else $error("input changed inside stretch time");
   AST_INRUSH: assert property (ctrl_reg[`B_INRUSH_EN] && inrush_cnt != '0 && !osc_err_reg |=> !osc_err_reg)
      else $error("short flagged inside inrush window");
   AST_SHORT_SET: assert property (!ctrl_reg[`B_INRUSH_EN] && ctrl_reg[`B_OSC_EN] && sh_s2[0] |=> osc_err_reg)
      else $error("short not flagged");
   AST_AUTO_CLR: assert property (!ctrl_reg[`B_RST_MODE] && !sh_s2[0] && osc_err_reg |=> !osc_err_reg)
      else $error("auto restart did not clear");
   AST_MANUAL: assert property (ctrl_reg[`B_RST_MODE] && osc_err_reg |=> osc_err_reg)
      else $error("manual short error released");
   AST_OPEN: assert property ($rose(status_reg[`S_OPEN_LO + 1]) |-> $past(ctrl_reg[`B_OPEN_EN]))
      else $error("open error while detection off");
   AST_FAULT_CLR: assert property (handheld && comm_fault_i && fault_act_reg[3:2] == 2'h0
                                   |=> !out_drv_reg[1])
      else $error("fault clear action not applied");
   AST_NO_HH: assert property (!handheld && (comm_fault_i || comm_idle_i) |=> !out_drv_reg[0])
      else $error("channel action used without handheld priority");
   AST_CNT_ERR: assert property (ctrl_reg[`B_CNT_EN] && cnt_reg[CH-1] > cnt_lim
                                 |=> status_reg[`S_CNT_LO + CH - 1])
      else $error("counter error not raised");
   AST_SAVE: assert property (seq_reg == SEQ_SAVE |-> ##(CH) seq_reg == SEQ_RUN)
      else $error("save sweep did not finish");
   AST_SUP: assert property (ctrl_reg[`B_SUP_EN] && sh_s2[1] |=> ##1 status_reg[`S_SUP])
      else $error("supply short not flagged");
   AST_COUNT: assert property (!rd_pend_reg && in_val_reg[0] && !in_prev_reg[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1)
      else $error("on count not incremented");
endmodule

// ==== sim/field_model.sv ====
// field side model: sensors, loads and supply sense lines
`timescale 1ns/1ps
module field_model (
   input  wire logic [3:0] sensor_i,
   input  wire logic       shorted_i,
   input  wire logic       sup_bad_i,
   input  wire logic [3:0] open_i,
   input  wire logic [3:0] out_drv_i,
   output logic      [3:0] in_pin_o,
   output logic            short_pin_o,
   output logic            sup_pin_o,
   output logic      [3:0] open_pin_o
);
   // a shorted load only draws excess current while some output powers it
   assign in_pin_o    = sensor_i;
   assign short_pin_o = shorted_i & (|out_drv_i);
   assign sup_pin_o   = sup_bad_i;
   assign open_pin_o  = open_i;
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the digital i/o channel conditioner
`timescale 1ns/1ps
`include "dio_cond_params.svh"
module tb;
   import dio_cond_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, q, rdat;
   logic        ack, fault = 1'b0, idle = 1'b0, shorted = 1'b0, sup_bad = 1'b0;
   logic        short_pin, sup_pin, irq;
   logic [3:0]  out_cmd = 4'h0, sensor = 4'h0, open_m = 4'h0, sel = 4'h0;
   logic [3:0]  in_pin, open_pin, in_val, out_drv;
   int          error_cnt = 0, tests_run = 0, cyc_cnt = 0, c0;
   // only the selections in use are shortened; the hour save becomes 200 cycles
   dio_channel_conditioner #(.FILT1_CYC(8), .STR1_CYC(32), .INRUSH_CYC(50),
      .SAVE_CYC(40'd200)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .in_pin_i(in_pin), .out_cmd_i(out_cmd), .comm_fault_i(fault),
      .comm_idle_i(idle), .out_short_pin_i(short_pin), .supply_short_pin_i(sup_pin),
      .out_open_pin_i(open_pin), .in_val_o(in_val), .out_drv_o(out_drv), .irq_o(irq));
   field_model fm (.sensor_i(sensor), .shorted_i(shorted), .sup_bad_i(sup_bad),
      .open_i(open_m), .out_drv_i(out_drv), .in_pin_o(in_pin), .short_pin_o(short_pin),
      .sup_pin_o(sup_pin), .open_pin_o(open_pin));
   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // the whole run needs some 2700 cycles; a hang is cut at 20000
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack is sampled high; only the timeout ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults;
      rd(`A_CTRL);
      chk("ctrl", `CTRL_RST, q);
      rd(`A_FAULT);
      chk("fault act", 32'h0, q);
      rd(`A_IDLE);
      chk("idle act", 32'h0, q);
      rd(8'hfc);
      chk("unmapped", 32'h0, q);
      rd(`A_THRESH);
      chk("thresh", 32'h1, q);
      wr(`A_THRESH, 32'h0000_ffff);
      rd(`A_THRESH);
      chk("thresh max", 32'h0000_fde8, q);
      wr(`A_THRESH, 32'h0);
      rd(`A_THRESH);
      chk("thresh min", 32'h1, q);
   endtask
   // a glitch is dropped; a pulse barely past the filter is stretched
   task automatic t_filter;
      @(posedge clk_i) sensor <= 4'h1;
      repeat (3) @(posedge clk_i);
      sensor <= 4'h0;
      repeat (20) @(posedge clk_i);
      chk("glitch", 1'b0, in_val[0]);
      sensor <= 4'h1;
      repeat (12) @(posedge clk_i);
      sensor <= 4'h0;
      repeat (20) @(posedge clk_i);
      chk("stretched", 1'b1, in_val[0]);
      repeat (40) @(posedge clk_i);
      chk("released", 1'b0, in_val[0]);
   endtask
   task automatic t_short;
      @(posedge clk_i) out_cmd <= 4'h1;
      shorted <= 1'b1;
      sup_bad <= 1'b1;
      repeat (10) @(posedge clk_i);
      rd(`A_LIVE);
      chk("live short", 2'h3, q[1:0]);
      rd(`A_STATUS);
      chk("status sup", 1'b1, q[0]);
      wr(`A_MASK, 32'h2);
      repeat (3) @(posedge clk_i);
      chk("irq set", 1'b1, irq);
      shorted <= 1'b0;
      sup_bad <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`A_LIVE);
      chk("auto clear", 2'h0, q[1:0]);
      wr(`A_STATUS, 32'h3);
      repeat (3) @(posedge clk_i);
      chk("irq clear", 1'b0, irq);
      wr(`A_CTRL, `CTRL_RST | 32'h2);
      out_cmd <= 4'h0;
      repeat (5) @(posedge clk_i);
      out_cmd <= 4'h1;
      shorted <= 1'b1;
      repeat (10) @(posedge clk_i);
      rd(`A_LIVE);
      chk("inrush masked", 1'b0, q[0]);
      repeat (60) @(posedge clk_i);
      rd(`A_LIVE);
      chk("after inrush", 1'b1, q[0]);
      wr(`A_CTRL, `CTRL_RST | 32'h8);
      shorted <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`A_LIVE);
      chk("manual latch", 1'b1, q[0]);
      wr(`A_MASK, 32'h0);
      open_m <= 4'h2;
      repeat (10) @(posedge clk_i);
      rd(`A_STATUS);
      chk("open off", 1'b0, q[9]);
      wr(`A_CTRL, `CTRL_RST | 32'h18);
      repeat (10) @(posedge clk_i);
      rd(`A_STATUS);
      chk("open on", 1'b1, q[9]);
      open_m <= 4'h0;
   endtask
   // fault: hold, off, force, off; idle: force, off, off, force
   task automatic t_actions;
      wr(`A_FAULT, 32'h21);
      wr(`A_IDLE, 32'h82);
      wr(`A_CTRL, `CTRL_RST | 32'h48);
      out_cmd <= 4'h3;
      repeat (5) @(posedge clk_i);
      chk("pass", 4'h3, out_drv);
      fault <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("fault act", 4'h5, out_drv);
      fault <= 1'b0;
      idle <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("idle act", 4'h9, out_drv);
      fault <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("fault first", 4'h5, out_drv);
      wr(`A_CTRL, `CTRL_RST | 32'h8);
      repeat (5) @(posedge clk_i);
      chk("no handheld", 4'h0, out_drv);
      fault <= 1'b0;
      idle <= 1'b0;
      out_cmd <= 4'h0;
   endtask
   // counts to the limit of 1 x 1000, one past it, then survives reset
   task automatic t_counter;
      wr(`A_CTRL, `CTRL_RST | 32'h28);
      rd(`A_COUNT + 8'h0c);
      c0 = int'(q);
      chk("base count", 32'd1, q);
      for (int i = c0; i < 1000; i++) begin
         @(posedge clk_i) out_cmd[3] <= 1'b1;
         @(posedge clk_i) out_cmd[3] <= 1'b0;
      end
      repeat (5) @(posedge clk_i);
      rd(`A_STATUS);
      chk("at limit", 1'b0, q[19]);
      @(posedge clk_i) out_cmd[3] <= 1'b1;
      repeat (5) @(posedge clk_i);
      rd(`A_STATUS);
      chk("over limit", 1'b1, q[19]);
      rd(`A_COUNT + 8'h0c);
      chk("count", 32'd1001, q);
      repeat (230) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(`A_COUNT + 8'h0c);
      chk("resumed", 32'd1001, q);
      rd(`A_LIVE);
      chk("power up", 1'b0, q[0]);
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_defaults();
      t_filter();
      t_short();
      t_actions();
      t_counter();
      stop_test();
   end
endmodule
